// ### design/ucs_regs.svh
// Purpose: Offsets, field positions and reset values of the configuration and security block
// Assumes: Included by the design modules, the flash model and the bench
// Notes: Definitions only
`ifndef UCS_REGS_SVH
`define UCS_REGS_SVH

// ==========================================================
// Register byte addresses
`define UCS_ADDR_W 8
`define UCS_ADDR_CONFIG 8'h00
`define UCS_ADDR_STATUS 8'h04
`define UCS_ADDR_MASK 8'h08
`define UCS_ADDR_SECURITY 8'h0C
`define UCS_ADDR_LASTOP 8'h10

// ==========================================================
// Configuration byte fields
`define UCS_CFG_CLK_MSB 2
`define UCS_CFG_CLK_LSB 0
`define UCS_CFG_RC_DBL 3
`define UCS_CFG_WD_SAFE 4
`define UCS_CFG_BOD 5
`define UCS_CFG_RST_PIN 6
`define UCS_CFG_WD_RST 7
`define UCS_CFG_RESET 8'h63

// ==========================================================
// Sector security fields
`define UCS_NUM_SECT 8
`define UCS_SECT_W 3
`define UCS_SEC_W 3
`define UCS_SEC_CRD 0
`define UCS_SEC_PED 1
`define UCS_SEC_ED 2
`define UCS_SEC_RESET 3'h0
`define UCS_SECT_ADDR_MSB 9
`define UCS_SECT_ADDR_LSB 7
`define UCS_FLASH_ADDR_W 10
`define UCS_INVALID_DATA 8'hFF

// ==========================================================
// Status and mask fields
`define UCS_STAT_W 2
`define UCS_STAT_PEV 0
`define UCS_STAT_CRCV 1
`define UCS_STAT_RESET 2'h0
`define UCS_PIN_IDLE 1'h1

`endif

// ### design/ucs_pkg.sv
// Purpose: Types shared by the configuration and security block
// Assumes: Offsets and fields come from ucs_regs.svh
// Notes: Enumerations only
`default_nettype none
package ucs_pkg;
   // ==========================================================
   // Clock source codes
   typedef enum logic [2:0] {
      CLK_RC = 3'h3,
      CLK_WDOSC = 3'h4,
      CLK_EXT = 3'h7
   } ucs_clk_t;

   // ==========================================================
   // Sequencer operation codes
   typedef enum logic [2:0] {
      OP_PROG = 3'h0,
      OP_PAGE_ERASE = 3'h1,
      OP_SECT_ERASE = 3'h2,
      OP_GLOBAL_ERASE = 3'h3,
      OP_SECT_CRC = 3'h4,
      OP_GLOBAL_CRC = 3'h5,
      OP_PROG_SEC = 3'h6
   } ucs_op_t;

   // ==========================================================
   // Load sequence states, one-hot
   typedef enum logic [1:0] {
      ST_LOAD = 2'b01,
      ST_RUN = 2'b10
   } ucs_state_t;
endpackage : ucs_pkg
`default_nettype wire

// ### design/ucs_pin_sync.sv
// Purpose: Three-stage synchroniser for the shared reset pin
// Assumes: Pin is asynchronous to clk
// Notes: Output follows once the second and third stages agree
`default_nettype none
`include "ucs_regs.svh"
module ucs_pin_sync
   import ucs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pinAsync,
   output logic pinLevel
);
   logic stage1;
   logic stage2;
   logic stage3;
   wire agree = (stage2 == stage3);

   // ==========================================================
   // Stage one feeds stage two only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= `UCS_PIN_IDLE;
         stage2 <= `UCS_PIN_IDLE;
         stage3 <= `UCS_PIN_IDLE;
         pinLevel <= `UCS_PIN_IDLE;
      end else begin
         stage1 <= pinAsync;
         stage2 <= stage1;
         stage3 <= stage2;
         if (agree) begin
            pinLevel <= stage3;
         end
      end
   end
endmodule : ucs_pin_sync
`default_nettype wire

// ### design/ucs_top.sv
// Purpose: User configuration decode and per-sector flash security gate
// Assumes: rst is the power-up reset; flash inputs are stable at its release
// Notes: APB slave with one wait state; outputs are registered
`default_nettype none
`include "ucs_regs.svh"
module ucs_top
   import ucs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`UCS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // Stored bytes from the flash array
   input wire logic [7:0] cfgByteIn,
   input wire logic [`UCS_NUM_SECT*`UCS_SEC_W-1:0] secBytesIn,
   // Decoded configuration
   output logic [2:0] clkSource,
   output logic clkSourceValid,
   output logic rcDoubler,
   output logic wdSafetyEn,
   output logic brownoutEn,
   output logic cfgLoaded,
   // Shared reset pin
   input wire logic sharedPinIn,
   output logic pinResetFunc,
   output logic pinResetReq,
   output logic pinGeneralIn,
   // Watchdog
   input wire logic wdTimeout,
   output logic wdResetReq,
   output logic wdIrqReq,
   // Table read path
   input wire logic tableReadReq,
   input wire logic [`UCS_FLASH_ADDR_W-1:0] tableReadAddr,
   input wire logic [7:0] arrayDataIn,
   output logic [7:0] tableReadData,
   output logic tableReadValid,
   // Operation gate for the programming sequencer
   input wire logic opReq,
   input wire logic [2:0] opCode,
   input wire logic [`UCS_SECT_W-1:0] opSector,
   input wire logic opExternal,
   input wire logic [`UCS_SEC_W-1:0] opSecData,
   output logic opGrant,
   output logic opViolation,
   output logic opUnchanged,
   output logic opCrcInvalid
);
   // ==========================================================
   // State and storage
   ucs_state_t state;
   ucs_state_t next_state;
   logic [7:0] cfg;
   logic [`UCS_SEC_W-1:0] secBits [`UCS_NUM_SECT];
   logic [`UCS_NUM_SECT*`UCS_SEC_W-1:0] secFlat;
   logic [`UCS_NUM_SECT-1:0] crdAny;
   logic [`UCS_NUM_SECT-1:0] edAny;
   logic [`UCS_STAT_W-1:0] status;
   logic [`UCS_STAT_W-1:0] mask;
   logic [`UCS_STAT_W-1:0] next_status;
   logic [7:0] lastOp;
   logic pinLevel;

   wire loading = (state == ST_LOAD);
   wire running = (state == ST_RUN);

   // ==========================================================
   // Load sequence
   always_comb begin
      next_state = state;
      unique case (state)
         ST_LOAD: begin
            next_state = ST_RUN;
         end
         ST_RUN: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_LOAD;
      end else begin
         state <= next_state;
      end
   end

   // Caught after release, since an async reset may only load constants
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg <= `UCS_CFG_RESET;
      end else if (loading) begin
         cfg <= cfgByteIn;
      end
   end

   // ==========================================================
   // Configuration decode
   wire [2:0] cfgClk = cfg[`UCS_CFG_CLK_MSB:`UCS_CFG_CLK_LSB];
   wire [2:0] loadClk = cfgByteIn[`UCS_CFG_CLK_MSB:`UCS_CFG_CLK_LSB];
   wire loadClkValid = (loadClk == CLK_RC) | (loadClk == CLK_WDOSC) | (loadClk == CLK_EXT);

   assign clkSource = cfgClk;
   assign rcDoubler = cfg[`UCS_CFG_RC_DBL];
   assign wdSafetyEn = cfg[`UCS_CFG_WD_SAFE];
   assign brownoutEn = cfg[`UCS_CFG_BOD];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clkSourceValid <= 1'h1;
         cfgLoaded <= 1'h0;
      end else if (loading) begin
         clkSourceValid <= loadClkValid;
         cfgLoaded <= 1'h1;
      end
   end

   // ==========================================================
   // Shared pin and watchdog
   ucs_pin_sync u_pin_sync (
      .clk(clk),
      .rst(rst),
      .pinAsync(sharedPinIn),
      .pinLevel(pinLevel)
   );

   // Pin stays a reset until the stored byte is in
   wire pinIsReset = loading | cfg[`UCS_CFG_RST_PIN];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinResetFunc <= 1'h1;
         pinResetReq <= 1'h0;
         pinGeneralIn <= 1'h0;
         wdResetReq <= 1'h0;
         wdIrqReq <= 1'h0;
      end else begin
         pinResetFunc <= pinIsReset;
         pinResetReq <= pinIsReset & ~pinLevel;
         pinGeneralIn <= ~pinIsReset & pinLevel;
         wdResetReq <= wdTimeout & cfg[`UCS_CFG_WD_RST];
         wdIrqReq <= wdTimeout;
      end
   end

   // ==========================================================
   // Security checks, evaluated before any grant
   wire [`UCS_SEC_W-1:0] opSec = secBits[opSector];
   wire opIsProgram = (opCode == OP_PROG) | (opCode == OP_PAGE_ERASE);
   wire opIsSectErase = (opCode == OP_SECT_ERASE);
   wire opIsGlobalErase = (opCode == OP_GLOBAL_ERASE);
   wire opIsSectCrc = (opCode == OP_SECT_CRC);
   wire opIsGlobalCrc = (opCode == OP_GLOBAL_CRC);
   wire opIsProgSec = (opCode == OP_PROG_SEC);
   wire opKnown = opIsProgram | opIsSectErase | opIsGlobalErase | opIsSectCrc
      | opIsGlobalCrc | opIsProgSec;
   // Reserved opcode 7 gets neither grant nor refusal, so the sequencer must not use it
   wire opTaken = running & opReq & opKnown;

   // Code-read bit is absent from every program and erase term
   wire progViol = opIsProgram & (opSec[`UCS_SEC_PED] | opSec[`UCS_SEC_ED]);
   wire sectEraseViol = opIsSectErase & opSec[`UCS_SEC_ED];
   wire globalEraseViol = opIsGlobalErase & ~opExternal & (|edAny);
   wire crcViol = (opIsSectCrc & opSec[`UCS_SEC_CRD]) | (opIsGlobalCrc & (|crdAny));
   wire peViol = progViol | sectEraseViol | globalEraseViol;
   wire anyViol = peViol | crcViol;
   wire grantNow = opTaken & ~anyViol;

   // ==========================================================
   // Per-sector protection fields
   genvar g;
   generate
      for (g = 0; g < `UCS_NUM_SECT; g = g + 1) begin : g_sect
         wire hit = (opSector == `UCS_SECT_W'(g));
         wire clearSect = grantNow & ((opIsSectErase & hit) | opIsGlobalErase);
         wire setSect = grantNow & opIsProgSec & hit;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               secBits[g] <= `UCS_SEC_RESET;
            end else if (loading) begin
               secBits[g] <= secBytesIn[g*`UCS_SEC_W +: `UCS_SEC_W];
            end else if (clearSect) begin
               secBits[g] <= `UCS_SEC_RESET;
            end else if (setSect) begin
               secBits[g] <= secBits[g] | opSecData;
            end
         end
         assign secFlat[g*`UCS_SEC_W +: `UCS_SEC_W] = secBits[g];
         assign crdAny[g] = secBits[g][`UCS_SEC_CRD];
         assign edAny[g] = secBits[g][`UCS_SEC_ED];
      end
   endgenerate

   // ==========================================================
   // Operation answer, one cycle after the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         opGrant <= 1'h0;
         opViolation <= 1'h0;
         opUnchanged <= 1'h0;
         opCrcInvalid <= 1'h0;
      end else begin
         opGrant <= grantNow;
         opViolation <= opTaken & anyViol;
         opUnchanged <= opTaken & anyViol;
         opCrcInvalid <= opTaken & crcViol;
      end
   end

   // Kept for software, which cannot see the pulsed answer
   wire [7:0] lastOpNext = {opSector, opCode, crcViol, peViol};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lastOp <= 8'h00;
      end else if (opTaken) begin
         lastOp <= lastOpNext;
      end
   end

   // ==========================================================
   // Table read path
   wire [`UCS_SECT_W-1:0] readSect = tableReadAddr[`UCS_SECT_ADDR_MSB:`UCS_SECT_ADDR_LSB];
   wire readBlocked = secBits[readSect][`UCS_SEC_CRD];
   wire [7:0] readValue = readBlocked ? `UCS_INVALID_DATA : arrayDataIn;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tableReadData <= 8'h00;
         tableReadValid <= 1'h0;
      end else begin
         tableReadValid <= tableReadReq & running;
         if (tableReadReq & running) begin
            tableReadData <= readValue;
         end
      end
   end

   // ==========================================================
   // APB decode
   wire apbAccess = psel & penable;
   wire apbDone = apbAccess & pready;
   wire apbWrite = apbDone & pwrite;
   wire apbFirst = apbAccess & ~pready;
   wire hitConfig = (paddr == `UCS_ADDR_CONFIG);
   wire hitStatus = (paddr == `UCS_ADDR_STATUS);
   wire hitMask = (paddr == `UCS_ADDR_MASK);
   wire hitSecurity = (paddr == `UCS_ADDR_SECURITY);
   wire hitLastOp = (paddr == `UCS_ADDR_LASTOP);
   wire addrHit = hitConfig | hitStatus | hitMask | hitSecurity | hitLastOp;
   // Configuration and security words are read only from the bus
   wire [31:0] cfgWord = {24'h000000, cfg};
   wire [31:0] statusWord = {30'h0, status};
   wire [31:0] maskWord = {30'h0, mask};
   wire [31:0] secWord = {8'h00, secFlat};
   wire [31:0] lastOpWord = {24'h000000, lastOp};
   wire [31:0] readMux =
      hitConfig ? cfgWord :
      hitStatus ? statusWord :
      hitMask ? maskWord :
      hitSecurity ? secWord :
      hitLastOp ? lastOpWord :
      32'h00000000;
   wire [`UCS_STAT_W-1:0] w1c = (apbWrite & hitStatus) ? pwdata[`UCS_STAT_W-1:0]
      : `UCS_STAT_RESET;
   wire [`UCS_STAT_W-1:0] events = {opTaken & crcViol, opTaken & peViol};

   // Set beats clear when both land together
   always_comb begin
      next_status = (status & ~w1c) | events;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'h0;
         pslverr <= 1'h0;
         prdata <= 32'h00000000;
      end else begin
         pready <= apbFirst;
         pslverr <= apbFirst & ~addrHit;
         if (apbFirst) begin
            prdata <= pwrite ? 32'h00000000 : readMux;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status <= `UCS_STAT_RESET;
      end else begin
         status <= next_status;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask <= `UCS_STAT_RESET;
      end else if (apbWrite & hitMask) begin
         mask <= pwdata[`UCS_STAT_W-1:0];
      end
   end

   // ==========================================================
   // Interrupt, registered so it trails the status bit by a cycle
   wire irqNext = |(status & mask);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'h0;
      end else begin
         irq <= irqNext;
      end
   end
endmodule : ucs_top
`default_nettype wire

// ### test/ucs_top_sva.sv
// Purpose: Concurrent checks on the configuration and security block ports
// Assumes: Single clock domain, rst is the power-up reset
// Notes: Bound into ucs_top at the foot of this file
`default_nettype none
module ucs_top_sva
   import ucs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic opReq,
   input wire logic [2:0] opCode,
   input wire logic opExternal,
   input wire logic opGrant,
   input wire logic opViolation,
   input wire logic opUnchanged,
   input wire logic opCrcInvalid,
   input wire logic cfgLoaded,
   input wire logic [2:0] clkSource,
   input wire logic clkSourceValid,
   input wire logic rcDoubler,
   input wire logic pinResetFunc,
   input wire logic pinGeneralIn,
   input wire logic wdTimeout,
   input wire logic wdIrqReq,
   input wire logic tableReadReq,
   input wire logic tableReadValid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ==========================================================
   // Sequences
   sequence apb_access;
      psel && penable && !pready;
   endsequence
   // Code 7 is ignored, so it carries no answer
   sequence op_taken;
      opReq && cfgLoaded && opCode != 3'h7;
   endsequence
   // ==========================================================
   // Properties
   a_apb_wait: assert property (apb_access |=> pready)
      else $error("bus answer not after one wait");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_op_answer: assert property (op_taken |=> opGrant != opViolation)
      else $error("operation not answered once");
   a_viol_unchanged: assert property (opViolation |-> opUnchanged && !opGrant)
      else $error("refusal without unchanged report");
   a_crc_invalid: assert property (opCrcInvalid |->
      opViolation && $past(opCode) inside {OP_SECT_CRC, OP_GLOBAL_CRC})
      else $error("invalid checksum outside refused checksum");
   a_ext_erase: assert property (
      op_taken ##0 (opCode == OP_GLOBAL_ERASE && opExternal) |=> opGrant)
      else $error("external global erase refused");
   a_cfg_frozen: assert property (cfgLoaded && $past(cfgLoaded, 2) |->
      $stable(clkSource) && $stable(rcDoubler) && $stable(pinResetFunc))
      else $error("configuration moved after load");
   a_load_pin: assert property (!cfgLoaded |-> pinResetFunc)
      else $error("pin not reset during load");
   a_pin_general: assert property (pinResetFunc |-> !pinGeneralIn)
      else $error("general input while pin is reset");
   a_clk_valid: assert property (
      clkSourceValid == (clkSource inside {CLK_RC, CLK_WDOSC, CLK_EXT}))
      else $error("clock valid flag wrong");
   a_wd_irq: assert property (wdTimeout |=> wdIrqReq)
      else $error("watchdog interrupt missing");
   a_table_valid: assert property (tableReadReq && cfgLoaded |=> tableReadValid)
      else $error("table read not answered");
   a_op_ignored: assert property (opReq && cfgLoaded && opCode == 3'h7 |=>
      !opGrant && !opViolation)
      else $error("reserved operation answered");
endmodule : ucs_top_sva

bind ucs_top ucs_top_sva u_sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .pready(pready), .opReq(opReq), .opCode(opCode), .opExternal(opExternal),
   .opGrant(opGrant), .opViolation(opViolation), .opUnchanged(opUnchanged),
   .opCrcInvalid(opCrcInvalid), .cfgLoaded(cfgLoaded), .clkSource(clkSource),
   .clkSourceValid(clkSourceValid), .rcDoubler(rcDoubler), .pinResetFunc(pinResetFunc),
   .pinGeneralIn(pinGeneralIn), .wdTimeout(wdTimeout), .wdIrqReq(wdIrqReq),
   .tableReadReq(tableReadReq), .tableReadValid(tableReadValid));
`default_nettype wire

// ### test/ucs_flash_model.sv
// Purpose: Flash array and stored configuration bytes beside the block
// Assumes: Array answers a read in the same cycle
// Notes: Data pattern is derived from the low address byte, so it repeats every 256 bytes
`default_nettype none
`include "ucs_regs.svh"
module ucs_flash_model (
   input wire logic [`UCS_FLASH_ADDR_W-1:0] readAddr,
   input wire logic [7:0] cfgImage,
   input wire logic [23:0] secImage,
   output logic [7:0] cfgByte,
   output logic [23:0] secBytes,
   output logic [7:0] arrayData
);
   // Stored bytes stay visible; the block alone decides when to latch them
   assign cfgByte = cfgImage;
   assign secBytes = secImage;
   assign arrayData = readAddr[7:0] ^ 8'h5A;
endmodule : ucs_flash_model
`default_nettype wire

// ### test/ucs_top_tb.sv
// Purpose: Self-checking bench for the configuration and security block
// Assumes: One wait state on the register bus, answers one cycle after requests
// Notes: Each scenario powers the block up again with its own stored bytes
`default_nettype none
`include "ucs_regs.svh"
module ucs_top_tb
   import ucs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, cfgLoaded, clkSourceValid;
   logic rcDoubler, wdSafetyEn, brownoutEn, sharedPinIn, pinResetFunc, pinResetReq;
   logic pinGeneralIn, wdTimeout, wdResetReq, wdIrqReq, tableReadReq, tableReadValid;
   logic opReq, opExternal, opGrant, opViolation, opUnchanged, opCrcInvalid;
   logic [7:0] paddr, cfgByteIn, arrayDataIn, tableReadData, cfgImage;
   logic [31:0] pwdata, prdata;
   logic [23:0] secBytesIn, secImage;
   logic [9:0] tableReadAddr;
   logic [2:0] clkSource, opCode, opSector, opSecData;
   int fails, nCompared;

   ucs_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .cfgByteIn(cfgByteIn), .secBytesIn(secBytesIn), .clkSource(clkSource),
      .clkSourceValid(clkSourceValid), .rcDoubler(rcDoubler), .wdSafetyEn(wdSafetyEn),
      .brownoutEn(brownoutEn), .cfgLoaded(cfgLoaded), .sharedPinIn(sharedPinIn),
      .pinResetFunc(pinResetFunc), .pinResetReq(pinResetReq), .pinGeneralIn(pinGeneralIn),
      .wdTimeout(wdTimeout), .wdResetReq(wdResetReq), .wdIrqReq(wdIrqReq),
      .tableReadReq(tableReadReq), .tableReadAddr(tableReadAddr), .arrayDataIn(arrayDataIn),
      .tableReadData(tableReadData), .tableReadValid(tableReadValid), .opReq(opReq),
      .opCode(opCode), .opSector(opSector), .opExternal(opExternal), .opSecData(opSecData),
      .opGrant(opGrant), .opViolation(opViolation), .opUnchanged(opUnchanged),
      .opCrcInvalid(opCrcInvalid));
   ucs_flash_model FLASH (.readAddr(tableReadAddr), .cfgImage(cfgImage),
      .secImage(secImage), .cfgByte(cfgByteIn), .secBytes(secBytesIn),
      .arrayData(arrayDataIn));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude;
      $display("compared %0d mismatches %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         conclude;
      end
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb

   task automatic pwr(input logic [7:0] cfg, input logic [23:0] sec);
      @(posedge clk) {rst, cfgImage, secImage} <= {1'b1, cfg, sec};
      repeat (5) @(posedge clk);
      chk(pinResetFunc, 1);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(cfgLoaded, 1);
   endtask : pwr

   task automatic op(input logic [2:0] c, input logic [2:0] s, input logic x,
      input logic v);
      @(posedge clk) {opReq, opCode, opSector, opExternal} <= {1'b1, c, s, x};
      @(posedge clk) opReq <= 1'b0;
      @(negedge clk);
      chk({opGrant, opViolation, opUnchanged}, {~v, v, v});
      chk(opCrcInvalid, v && c inside {OP_SECT_CRC, OP_GLOBAL_CRC});
   endtask : op

   task automatic tread(input logic [9:0] a, input logic [7:0] exp);
      @(posedge clk) {tableReadReq, tableReadAddr} <= {1'b1, a};
      @(posedge clk) tableReadReq <= 1'b0;
      @(negedge clk);
      chk({tableReadValid, tableReadData}, {1'b1, exp});
   endtask : tread
   // ==========================================================
   // Scenarios
   task automatic cfg_case(input logic [7:0] cfg);
      logic [31:0] r;
      logic e;
      pwr(cfg, 24'h0);
      chk(clkSource, cfg[2:0]);
      chk(clkSourceValid, cfg[2:0] inside {3'h3, 3'h4, 3'h7});
      chk(rcDoubler, cfg[3]);
      chk({brownoutEn, wdSafetyEn}, cfg[5:4]);
      chk(pinResetFunc, cfg[6]);
      apb(1'b1, `UCS_ADDR_CONFIG, {24'h0, ~cfg}, r, e);
      cfgImage <= ~cfg;
      apb(1'b0, `UCS_ADDR_CONFIG, 32'h0, r, e);
      chk(r, {24'h0, cfg});
      chk(clkSource, cfg[2:0]);
      wdTimeout <= 1'b1;
      @(posedge clk) wdTimeout <= 1'b0;
      @(negedge clk);
      chk({wdResetReq, wdIrqReq}, {cfg[7], 1'b1});
      @(posedge clk) sharedPinIn <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk({pinResetReq, pinGeneralIn}, {cfg[6], 1'b0});
      @(posedge clk) sharedPinIn <= 1'b1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk({pinResetReq, pinGeneralIn}, {1'b0, ~cfg[6]});
   endtask : cfg_case

   task automatic sec_case;
      logic [31:0] r;
      logic e;
      // Sector 0 read-protected, 1 write-protected, 2 erase-protected
      pwr(8'h63, 24'h000111);
      tread(10'h005, 8'hFF);
      tread(10'h185, 8'h85 ^ 8'h5A);
      op(OP_PROG, 3'h0, 1'b0, 1'b0);
      op(OP_PAGE_ERASE, 3'h0, 1'b0, 1'b0);
      op(OP_SECT_CRC, 3'h0, 1'b0, 1'b1);
      op(OP_GLOBAL_CRC, 3'h3, 1'b0, 1'b1);
      op(OP_SECT_CRC, 3'h1, 1'b0, 1'b0);
      op(OP_PROG, 3'h1, 1'b0, 1'b1);
      op(OP_PAGE_ERASE, 3'h1, 1'b0, 1'b1);
      op(OP_PROG, 3'h2, 1'b0, 1'b1);
      op(OP_SECT_ERASE, 3'h2, 1'b0, 1'b1);
      op(OP_GLOBAL_ERASE, 3'h3, 1'b0, 1'b1);
      apb(1'b0, `UCS_ADDR_STATUS, 32'h0, r, e);
      chk(r, 32'h3);
      apb(1'b0, `UCS_ADDR_LASTOP, 32'h0, r, e);
      chk(r, 32'h6D);
      chk(irq, 0);
      apb(1'b1, `UCS_ADDR_MASK, 32'h2, r, e);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(irq, 1);
      apb(1'b1, `UCS_ADDR_STATUS, 32'h2, r, e);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(irq, 0);
      apb(1'b0, `UCS_ADDR_STATUS, 32'h0, r, e);
      chk(r, 32'h1);
      op(OP_SECT_ERASE, 3'h1, 1'b0, 1'b0);
      op(OP_PROG, 3'h1, 1'b0, 1'b0);
      op(OP_SECT_ERASE, 3'h0, 1'b0, 1'b0);
      tread(10'h005, 8'h05 ^ 8'h5A);
      op(OP_GLOBAL_CRC, 3'h3, 1'b0, 1'b0);
      op(OP_PROG_SEC, 3'h3, 1'b0, 1'b0);
      op(OP_SECT_CRC, 3'h3, 1'b0, 1'b1);
      op(OP_GLOBAL_ERASE, 3'h3, 1'b1, 1'b0);
      op(OP_PROG, 3'h2, 1'b0, 1'b0);
      apb(1'b0, `UCS_ADDR_SECURITY, 32'h0, r, e);
      chk(r, 32'h0);
      // Unmapped word answers with an error and zero data
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk(e, 1'b1);
      chk(r, 32'h0);
      // Reserved operation code draws no answer at all
      @(posedge clk) {opReq, opCode} <= {1'b1, 3'h7};
      @(posedge clk) opReq <= 1'b0;
      @(negedge clk);
      chk({opGrant, opViolation, opUnchanged}, 3'h0);
   endtask : sec_case
   // ==========================================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, wdTimeout, tableReadReq} = '0;
      {tableReadAddr, opReq, opCode, opSector, opExternal} = '0;
      rst = 1'b1;
      sharedPinIn = 1'b1;
      opSecData = 3'h1;
      cfgImage = 8'h63;
      secImage = 24'h0;
      fails = 0;
      nCompared = 0;
      cfg_case(8'hFF);
      cfg_case(8'h04);
      cfg_case(8'h3A);
      cfg_case(8'h63);
      sec_case;
      conclude;
   end
endmodule : ucs_top_tb
`default_nettype wire
